//--- shared/timer8_pkg.sv
package timer8_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] CTRL_TWO_OFS = 4'h0;
    localparam logic [3:0] CTRL_ONE_OFS = 4'h1;
    localparam logic [3:0] STATUS_OFS = 4'h2;
    localparam logic [3:0] CAP1_OFS = 4'h3;
    localparam logic [3:0] CMP1_OFS = 4'h4;
    localparam logic [3:0] MAIN_CNT_OFS = 4'h5;
    localparam logic [3:0] ALT_CNT_OFS = 4'h6;
    localparam logic [3:0] CAP2_OFS = 4'h7;
    localparam logic [3:0] CMP2_OFS = 4'h8;
    // control_reg_one fields
    localparam int LVL1_BIT = 0;
    localparam int EDGE1_BIT = 1;
    localparam int LVL2_BIT = 2;
    localparam int FORCE1_BIT = 3;
    localparam int FORCE2_BIT = 4;
    localparam int OVF_IE_BIT = 5;
    localparam int CMP_IE_BIT = 6;
    localparam int CAP_IE_BIT = 7;
    // control_reg_two fields
    localparam int EDGE2_BIT = 1;
    localparam int SEL_LO_BIT = 2;
    localparam int PWM_BIT = 4;
    localparam int ONE_PULSE_BIT = 5;
    localparam int PIN2_EN_BIT = 6;
    localparam int PIN1_EN_BIT = 7;
    // flag vector index, status bit = index + FLAG_BASE
    localparam int FL_CMP2 = 0;
    localparam int FL_CAP2 = 1;
    localparam int FL_OVF = 2;
    localparam int FL_CMP1 = 3;
    localparam int FL_CAP1 = 4;
    localparam int FLAG_BASE = 3;
    // reset and reload values
    localparam logic [7:0] CNT_RELOAD = 8'hfc;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] CAP_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // clock select codes
    localparam logic [1:0] SEL_DIV2 = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_OSC = 2'h3;
    // last count of each divider
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam int OSC_DIV = 8000;
    localparam logic [12:0] OSC_LAST = 13'(OSC_DIV - 1);
endpackage

//--- src/timer8_prescaler.sv
`timescale 1ns/1ps
module timer8_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    input wire logic osc_tick,
    input wire logic run,
    output logic tick
);
    logic [2:0] core_q;
    logic [2:0] core_d;
    logic [12:0] osc_q;
    logic [12:0] osc_d;
    logic [2:0] core_last;

    // terminal count of the core-clock divider for a select code
    // select code map
    function automatic logic [2:0] last_of(input logic [1:0] s);
        case (s)
            timer8_pkg::SEL_DIV2: last_of = timer8_pkg::DIV2_LAST;
            timer8_pkg::SEL_DIV4: last_of = timer8_pkg::DIV4_LAST;
            default: last_of = timer8_pkg::DIV8_LAST;
        endcase
    endfunction

    // both dividers freeze while halted so the count resumes in phase
    always_comb begin
        core_last = last_of(sel);
        core_d = core_q;
        osc_d = osc_q;
        tick = 1'b0;
        if (run) begin
            core_d = (core_q >= core_last) ? 3'h0 : core_q + 3'h1;
            if (osc_tick) begin
                osc_d = (osc_q == timer8_pkg::OSC_LAST) ? 13'h0000 : osc_q + 13'h0001;
            end
            if (sel == timer8_pkg::SEL_OSC) begin
                tick = osc_tick && (osc_q == timer8_pkg::OSC_LAST);
            end else begin
                tick = (core_q >= core_last);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_q <= 3'h0;
            osc_q <= 13'h0000;
        end else begin
            core_q <= core_d;
            osc_q <= osc_d;
        end
    end
endmodule

//--- src/timer8_core.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// How it works
// - an 8-bit free-running up-counter, readable through two count registers
// - any write to main or alternate count register reloads FCh
// - counter resets to FCh and FCh is the only reload value
// - two-bit clock select picks core/2, /4, /8 or half-osc/8000
// - core dividers give a full count period of 512, 1024, 2048 cycles
// - overflow flag sets when the counter wraps from FFh to 00h
// - overflow request needs flag, enable and a clear processor mask
// - overflow flag clears by status read then main count access only
// - counter runs in wait, holds its count while halted
// - active capture edge copies the counter into read-only capture register
// - capture sets its flag; request gated by capture enable and mask
// - capture flag clears by status read then its capture register access
// - one-pulse and pulse-width modes leave only capture channel 2
// - capture inputs always feed the edge detectors
// - each timer tick compares both compare registers and flags matches
// - compare registers are software-only and reset to 00h
// - enabled pin takes the level bit on a match, else stays undriven
// - compare output latches are low during reset
// - compare flag clears by status read then its compare register access
// - divide-by-2 matches at the value, slower clocks at value plus one
// - force bits copy level to pin without flag; inert in special modes
module timer8_core (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic HALF_OSC_TICK,
    input wire logic HALT,
    input wire logic IRQ_MASK,
    input wire logic [1:0] CAPTURE_INPUT_PIN,
    output logic [1:0] COMPARE_OUTPUT_PIN,
    output logic [1:0] COMPARE_PIN_OE,
    output logic TIMER_IRQ
);
    logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
    logic [7:0] count_q, count_d;
    logic [7:0] cap_q [2];
    logic [7:0] cap_d [2];
    logic [7:0] cmp_q [2];
    logic [7:0] cmp_d [2];
    logic [4:0] flag_q, flag_d, armed_q, armed_d, flag_set, flag_clr;
    logic [1:0] pin_q, pin_d, in_q, in_d, cap_ev, cmp_ev, level;
    logic [7:0] rdata_q, rdata_d;
    logic tick, special, cnt_wr, wrap, fast;
    logic [7:0] cmp_ref;

    // register that owns the clearing access of each flag
    function automatic logic [3:0] clr_ofs(input int idx);
        case (idx)
            timer8_pkg::FL_CMP2: clr_ofs = timer8_pkg::CMP2_OFS;
            timer8_pkg::FL_CAP2: clr_ofs = timer8_pkg::CAP2_OFS;
            timer8_pkg::FL_OVF: clr_ofs = timer8_pkg::MAIN_CNT_OFS;
            timer8_pkg::FL_CMP1: clr_ofs = timer8_pkg::CMP1_OFS;
            default: clr_ofs = timer8_pkg::CAP1_OFS;
        endcase
    endfunction

    timer8_prescaler u_presc (
        .clk(CLK),
        .rst_n(RST_N),
        .sel(ctrl2_q[timer8_pkg::SEL_LO_BIT +: 2]),
        .osc_tick(HALF_OSC_TICK),
        .run(!HALT),
        .tick(tick)
    );

    assign special = ctrl2_q[timer8_pkg::ONE_PULSE_BIT] | ctrl2_q[timer8_pkg::PWM_BIT];
    assign fast = (ctrl2_q[timer8_pkg::SEL_LO_BIT +: 2] == timer8_pkg::SEL_DIV2);
    assign level = {ctrl1_q[timer8_pkg::LVL2_BIT], ctrl1_q[timer8_pkg::LVL1_BIT]};
    assign cnt_wr = WR && (ADDR == timer8_pkg::MAIN_CNT_OFS || ADDR == timer8_pkg::ALT_CNT_OFS);
    assign wrap = tick && (count_q == timer8_pkg::CNT_TOP);

    // counter: tick advances, halt stops the prescaler and so the count
    always_comb begin
        count_d = count_q;
        if (tick) begin
            count_d = count_q + 8'h01;
        end
        if (cnt_wr) begin
            count_d = timer8_pkg::CNT_RELOAD;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_q <= timer8_pkg::CNT_RELOAD;
        end else begin
            count_q <= count_d;
        end
    end

    // capture edges; inputs are synchronous so no extra flop stage
    always_comb begin
        in_d = CAPTURE_INPUT_PIN;
        cap_d = cap_q;
        for (int i = 0; i < 2; i++) begin
            logic sel_rise;
            sel_rise = (i == 0) ? ctrl1_q[timer8_pkg::EDGE1_BIT]
                                : ctrl2_q[timer8_pkg::EDGE2_BIT];
            cap_ev[i] = sel_rise ? (CAPTURE_INPUT_PIN[i] & ~in_q[i])
                                 : (~CAPTURE_INPUT_PIN[i] & in_q[i]);
        end
        // channel 1 is taken by the special modes
        if (special) begin
            cap_ev[0] = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (cap_ev[i]) begin
                cap_d[i] = count_q;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_q <= 2'h0;
            cap_q[0] <= timer8_pkg::CAP_RST;
            cap_q[1] <= timer8_pkg::CAP_RST;
        end else begin
            in_q <= in_d;
            cap_q <= cap_d;
        end
    end

    // compare: at /2 the match shows as the counter reaches the value,
    // at slower rates one count later, so the reference differs
    always_comb begin
        cmp_ref = fast ? count_q + 8'h01 : count_q;
        pin_d = pin_q;
        for (int i = 0; i < 2; i++) begin
            cmp_ev[i] = tick && (cmp_ref == cmp_q[i]);
            // level reaches the latch on a match
            if (cmp_ev[i]) begin
                pin_d[i] = level[i];
            end
        end
        // force copies new level, no flag, not in special modes
        if (WR && ADDR == timer8_pkg::CTRL_ONE_OFS && !special) begin
            if (WDATA[timer8_pkg::FORCE1_BIT]) begin
                pin_d[0] = WDATA[timer8_pkg::LVL1_BIT];
            end
            if (WDATA[timer8_pkg::FORCE2_BIT]) begin
                pin_d[1] = WDATA[timer8_pkg::LVL2_BIT];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_q <= 2'h0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign COMPARE_OUTPUT_PIN = pin_q;
    assign COMPARE_PIN_OE = {ctrl2_q[timer8_pkg::PIN2_EN_BIT],
                             ctrl2_q[timer8_pkg::PIN1_EN_BIT]};

    // flags: a status read arms each set flag, the owning access clears it
    always_comb begin
        flag_set = '0;
        flag_set[timer8_pkg::FL_OVF] = wrap;
        flag_set[timer8_pkg::FL_CAP1] = cap_ev[0];
        flag_set[timer8_pkg::FL_CAP2] = cap_ev[1];
        flag_set[timer8_pkg::FL_CMP1] = cmp_ev[0];
        flag_set[timer8_pkg::FL_CMP2] = cmp_ev[1];
        armed_d = armed_q;
        if (RD && ADDR == timer8_pkg::STATUS_OFS) begin
            armed_d = armed_q | flag_q;
        end
        for (int i = 0; i < 5; i++) begin
            flag_clr[i] = armed_q[i] && (WR || RD) && (ADDR == clr_ofs(i));
            if (flag_clr[i]) begin
                armed_d[i] = 1'b0;
            end
        end
        // a new event in the clearing cycle survives
        flag_d = (flag_q & ~flag_clr) | flag_set;
        armed_d = armed_d & flag_d;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_q <= 5'h00;
            armed_q <= 5'h00;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    // pending flags gated by enables and mask
    assign TIMER_IRQ = !IRQ_MASK && (
        (flag_q[timer8_pkg::FL_OVF] && ctrl1_q[timer8_pkg::OVF_IE_BIT]) ||
        ((flag_q[timer8_pkg::FL_CAP1] || flag_q[timer8_pkg::FL_CAP2]) &&
         ctrl1_q[timer8_pkg::CAP_IE_BIT]) ||
        ((flag_q[timer8_pkg::FL_CMP1] || flag_q[timer8_pkg::FL_CMP2]) &&
         ctrl1_q[timer8_pkg::CMP_IE_BIT]));

    // software registers; force bits are write-only pulses
    always_comb begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        cmp_d = cmp_q;
        if (WR) begin
            case (ADDR)
                timer8_pkg::CTRL_ONE_OFS: begin
                    ctrl1_d = WDATA;
                    ctrl1_d[timer8_pkg::FORCE1_BIT] = 1'b0;
                    ctrl1_d[timer8_pkg::FORCE2_BIT] = 1'b0;
                end
                timer8_pkg::CTRL_TWO_OFS: ctrl2_d = WDATA & 8'hfe;
                // compare registers only change by software
                timer8_pkg::CMP1_OFS: cmp_d[0] = WDATA;
                timer8_pkg::CMP2_OFS: cmp_d[1] = WDATA;
                default: ctrl1_d = ctrl1_q;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl1_q <= timer8_pkg::CTRL_RST;
            ctrl2_q <= timer8_pkg::CTRL_RST;
            cmp_q[0] <= timer8_pkg::CMP_RST;
            cmp_q[1] <= timer8_pkg::CMP_RST;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            cmp_q <= cmp_d;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = 8'h00;
        if (RD) begin
            case (ADDR)
                timer8_pkg::CTRL_ONE_OFS: rdata_d = ctrl1_q;
                timer8_pkg::CTRL_TWO_OFS: rdata_d = ctrl2_q;
                timer8_pkg::STATUS_OFS: rdata_d = {flag_q, 3'h0};
                timer8_pkg::CAP1_OFS: rdata_d = cap_q[0];
                timer8_pkg::CAP2_OFS: rdata_d = cap_q[1];
                timer8_pkg::CMP1_OFS: rdata_d = cmp_q[0];
                timer8_pkg::CMP2_OFS: rdata_d = cmp_q[1];
                // both count registers show the counter
                timer8_pkg::MAIN_CNT_OFS: rdata_d = count_q;
                timer8_pkg::ALT_CNT_OFS: rdata_d = count_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    cnt_reload_a: assert property (cnt_wr |=> count_q == 8'hfc)
        else $error("count write did not reload");
    wrap_flag_a: assert property (wrap && !cnt_wr |=> flag_q[2] && count_q == 8'h00)
        else $error("wrap did not set overflow");
    irq_mask_a: assert property (TIMER_IRQ |-> !IRQ_MASK)
        else $error("request while masked");
    alt_keep_a: assert property (
        flag_q[2] && (WR || RD) && ADDR == 4'h6 |=> flag_q[2])
        else $error("alternate access cleared overflow");
    ovf_clear_a: assert property (
        armed_q[2] && RD && ADDR == 4'h5 && !wrap |=> !flag_q[2])
        else $error("overflow not cleared");
    halt_hold_a: assert property (
        HALT && !cnt_wr |=> count_q == $past(count_q))
        else $error("counter moved while halted");
    cap_load_a: assert property (
        cap_ev[1] |=> cap_q[1] == $past(count_q) && flag_q[1])
        else $error("capture 2 not loaded");
    cap1_block_a: assert property (
        special |=> cap_q[0] == $past(cap_q[0]))
        else $error("capture 1 active in special mode");
    cmp_stable_a: assert property (
        !(WR && ADDR == 4'h4) |=> cmp_q[0] == $past(cmp_q[0]))
        else $error("compare 1 changed by hardware");
    force_noflag_a: assert property (
        WR && ADDR == 4'h1 && WDATA[3] && !special && !cmp_ev[0]
        |=> pin_q[0] == $past(WDATA[0]) && flag_q[3] == $past(flag_q[3]))
        else $error("force misbehaved");

    irq_ovf_a: assert property (
        flag_q[2] && ctrl1_q[5] && !IRQ_MASK |-> TIMER_IRQ)
        else $error("overflow request missing");
    cap_flag_a: assert property (
        cap_ev[0] |=> flag_q[4] && cap_q[0] == $past(count_q))
        else $error("capture 1 not flagged");
    cmp_flag_a: assert property (
        cmp_ev[0] |=> flag_q[3])
        else $error("compare match not flagged");
    cmp_pin_a: assert property (
        cmp_ev[1] && !(WR && ADDR == 4'h1) |=> pin_q[1] == $past(level[1]))
        else $error("compare pin missed level");
    fast_match_a: assert property (
        cmp_ev[0] && fast && !cnt_wr |=> count_q == $past(cmp_q[0]))
        else $error("fast match off the compare value");

    wrap_c: cover property (wrap ##1 TIMER_IRQ);
    cap2_c: cover property (cap_ev[1] ##1 TIMER_IRQ);
    force_c: cover property (WR && ADDR == 4'h1 && WDATA[4] && !special);
    cap_c: cover property (cap_ev[0] ##[1:20] RD && ADDR == 4'h3);
    cmp_c: cover property (cmp_ev[1] && COMPARE_PIN_OE[1]);
endmodule

//--- dv/pin_side.sv
`timescale 1ns/1ps
// far side of the timer pins: capture sources and compare pin loads
module pin_side (
    input wire logic clk,
    input wire logic [1:0] cap_cmd,
    input wire logic [1:0] cmp_out,
    input wire logic [1:0] cmp_oe,
    output logic [1:0] cap_pin,
    output logic [1:0] pin_lvl
);
    logic [1:0] last_q = 2'h0;
    // sources move just after an edge
    always_ff @(posedge clk) begin
        cap_pin <= cap_cmd;
    end
    always_ff @(posedge clk) begin
        last_q <= (cmp_oe & cmp_out) | (~cmp_oe & last_q);
    end
    // no pull on these lines, so a stale level must not look valid
    assign pin_lvl = (cmp_oe & cmp_out) | (~cmp_oe & ~last_q);
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic osc_tick = 1'b1;
    logic halt = 1'b1;
    logic irq_mask = 1'b0;
    logic [1:0] cap_cmd = 2'h0;
    logic rd_pend = 1'b0;
    logic [7:0] rdata;
    logic [1:0] cap_pin;
    logic [1:0] cmp_out;
    logic [1:0] cmp_oe;
    logic [1:0] pin_lvl;
    logic irq;
    logic [7:0] r;
    logic [15:0] exp_q[$];
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int t0;
    wire logic [2:0] obs = {pin_lvl, irq};

    timer8_core DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .HALF_OSC_TICK(osc_tick), .HALT(halt),
        .IRQ_MASK(irq_mask), .CAPTURE_INPUT_PIN(cap_pin), .COMPARE_OUTPUT_PIN(cmp_out),
        .COMPARE_PIN_OE(cmp_oe), .TIMER_IRQ(irq));
    pin_side PINS (.clk(clk), .cap_cmd(cap_cmd), .cmp_out(cmp_out), .cmp_oe(cmp_oe),
        .cap_pin(cap_pin), .pin_lvl(pin_lvl));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_pend <= rd_s;
    end

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask

    // read data stands only in the cycle after the strobe, so look mid-cycle
    always @(negedge clk) begin
        if (rd_pend === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("BAD rdata exp note got none");
            end else begin
                chk("rdata", {8'h00, exp_q[0][7:0] & exp_q[0][15:8]},
                    {8'h00, rdata & exp_q[0][15:8]});
                void'(exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        exp_q.push_back({m, e});
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    // status read arms, owner access clears
    task automatic clr(input logic [3:0] a);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h00);
        rd(a, 8'h00, 8'h00);
    endtask

    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (obs[s] !== 1'b1 && n < lim);
        if (obs[s] !== 1'b1) begin
            fails++;
            $display("BAD wait %0d exp 1 got 0", s);
            end_sim();
        end
    endtask

    initial begin
        void'($urandom(40397));
        repeat (8) @(posedge clk);
        chk("pins in reset", 16'h0, {14'h0, cmp_out});
        rst_n <= 1'b1;
        // reset values while halted, unmapped offset reads zero
        rd(timer8_pkg::MAIN_CNT_OFS, 8'hfc, 8'hff);
        rd(timer8_pkg::CMP1_OFS, 8'h00, 8'hff);
        rd(timer8_pkg::CMP2_OFS, 8'h00, 8'hff);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'hff);
        rd(4'h9, 8'h00, 8'hff);
        r = 8'($urandom());
        wr(timer8_pkg::CMP1_OFS, r);
        rd(timer8_pkg::CMP1_OFS, r, 8'hff);
        $display("test reset values done");
        // overflow period for each core divider
        wr(timer8_pkg::CTRL_ONE_OFS, 8'h20);
        for (int s = 0; s < 3; s++) begin
            wr(timer8_pkg::CTRL_TWO_OFS, {4'h0, 2'(s), 2'h0});
            halt <= 1'b0;
            wait_hi(0, 4500);
            t0 = cyc;
            clr(timer8_pkg::MAIN_CNT_OFS);
            rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h20);
            wait_hi(0, 2100);
            chk("period", 16'(512 << s), 16'(cyc - t0));
            clr(timer8_pkg::MAIN_CNT_OFS);
        end
        $display("test periods done");
        // half-osc divider, ticks every cycle here
        @(posedge clk);
        halt <= 1'b1;
        wr(timer8_pkg::CTRL_TWO_OFS, 8'h0c);
        wr(timer8_pkg::MAIN_CNT_OFS, 8'h00);
        halt <= 1'b0;
        t0 = cyc;
        wait_hi(0, 33000);
        chk("osc overflow", 16'h1, {15'h0, (cyc - t0 >= 24000) && (cyc - t0 <= 32002)});
        @(posedge clk);
        halt <= 1'b1;
        irq_mask <= 1'b1;
        @(negedge clk);
        chk("irq masked", 16'h0, {15'h0, irq});
        rd(timer8_pkg::STATUS_OFS, 8'h20, 8'h20);
        rd(timer8_pkg::ALT_CNT_OFS, 8'h00, 8'h00);
        rd(timer8_pkg::STATUS_OFS, 8'h20, 8'h20);
        irq_mask <= 1'b0;
        @(negedge clk);
        chk("irq pending", 16'h1, {15'h0, irq});
        wr(timer8_pkg::ALT_CNT_OFS, 8'($urandom()));
        rd(timer8_pkg::MAIN_CNT_OFS, 8'hfc, 8'hff);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h20);
        $display("test overflow flag done");
        // captures while frozen at the reload value
        wr(timer8_pkg::CTRL_ONE_OFS, 8'h82);
        wr(timer8_pkg::CTRL_TWO_OFS, 8'h00);
        cap_cmd <= 2'h3;
        // pin model needs an edge, the flag one more
        @(posedge clk);
        rd(timer8_pkg::STATUS_OFS, 8'h80, 8'h90);
        @(negedge clk);
        chk("irq capture", 16'h1, {15'h0, irq});
        rd(timer8_pkg::CAP1_OFS, 8'hfc, 8'hff);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h80);
        cap_cmd <= 2'h0;
        @(posedge clk);
        rd(timer8_pkg::STATUS_OFS, 8'h10, 8'h90);
        clr(timer8_pkg::CAP2_OFS);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h10);
        wr(timer8_pkg::CTRL_TWO_OFS, 8'h20);
        cap_cmd <= 2'h3;
        @(posedge clk);
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h80);
        cap_cmd <= 2'h0;
        @(posedge clk);
        rd(timer8_pkg::STATUS_OFS, 8'h10, 8'h10);
        clr(timer8_pkg::CAP2_OFS);
        $display("test capture done");
        // compare match, pin and timing, channel 1 at /2 and channel 2 at /8
        for (int ch = 0; ch < 2; ch++) begin
            r = 8'($urandom_range(8'hf0, 8'h10));
            wr(ch ? timer8_pkg::CMP2_OFS : timer8_pkg::CMP1_OFS, r);
            wr(timer8_pkg::CTRL_ONE_OFS, ch ? 8'h44 : 8'h41);
            wr(timer8_pkg::CTRL_TWO_OFS, ch ? 8'h48 : 8'h80);
            // stale match flags from earlier runs would hide a missing one
            clr(timer8_pkg::CMP1_OFS);
            clr(timer8_pkg::CMP2_OFS);
            @(negedge clk);
            chk("irq idle", 16'h0, {15'h0, irq});
            @(posedge clk);
            halt <= 1'b0;
            @(negedge clk);
            chk("pin enable", ch ? 16'h2 : 16'h1, {14'h0, cmp_oe});
            wait_hi(1 + ch, 2300);
            rd(timer8_pkg::ALT_CNT_OFS, r + 8'(ch), 8'hff);
            @(negedge clk);
            chk("irq compare", 16'h1, {15'h0, irq});
            rd(timer8_pkg::STATUS_OFS, ch ? 8'h08 : 8'h40, ch ? 8'h08 : 8'h40);
            rd(ch ? timer8_pkg::CMP2_OFS : timer8_pkg::CMP1_OFS, r, 8'hff);
            rd(timer8_pkg::STATUS_OFS, 8'h00, ch ? 8'h08 : 8'h40);
            halt <= 1'b1;
        end
        $display("test compare done");
        // forcing sets pins without flags, inert in one-pulse mode
        clr(timer8_pkg::CMP1_OFS);
        wr(timer8_pkg::CTRL_TWO_OFS, 8'hc0);
        wr(timer8_pkg::CTRL_ONE_OFS, 8'h08);
        @(negedge clk);
        chk("forced pins", 16'h2, {14'h0, pin_lvl});
        rd(timer8_pkg::STATUS_OFS, 8'h00, 8'h48);
        wr(timer8_pkg::CTRL_TWO_OFS, 8'he0);
        wr(timer8_pkg::CTRL_ONE_OFS, 8'h1d);
        @(negedge clk);
        chk("force in opm", 16'h2, {14'h0, pin_lvl});
        wr(timer8_pkg::CTRL_TWO_OFS, 8'hc0);
        wr(timer8_pkg::CTRL_ONE_OFS, 8'h1d);
        @(negedge clk);
        chk("forced high", 16'h3, {14'h0, pin_lvl});
        wr(timer8_pkg::CTRL_TWO_OFS, 8'h00);
        @(negedge clk);
        chk("pins released", 16'h0, {14'h0, cmp_oe});
        $display("test force done");
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("pins in reset", 16'h0, {14'h0, cmp_out});
        @(posedge clk);
        rst_n <= 1'b1;
        rd(timer8_pkg::MAIN_CNT_OFS, 8'hfc, 8'hff);
        rd(timer8_pkg::CMP1_OFS, 8'h00, 8'hff);
        repeat (3) @(posedge clk);
        $display("test second reset done");
        end_sim();
    end
endmodule
